// ### rtl/flash_guard_regs.svh
`ifndef FLASH_GUARD_REGS_SVH
`define FLASH_GUARD_REGS_SVH

// register byte offsets
`define REG_STATUS 8'h00
`define REG_LOCKS 8'h04
`define REG_BOOT_START 8'h08
`define REG_OP_TIME 8'h0C
`define REG_VECTOR 8'h10

// lock register fields, 1 = unprogrammed, 0 = programmed
`define LOCK_APP_WR 0
`define LOCK_APP_RD 1
`define LOCK_BOOT_WR 2
`define LOCK_BOOT_RD 3

// status register fields
`define ST_PROG_BUSY 0
`define ST_CONC_BUSY 1
`define ST_CPU_HALT 2
`define ST_STORE_REFUSED 3
`define ST_LOAD_REFUSED 4

// vector register field
`define VEC_IN_BOOT 0

// flash word address width and fixed section limit
`define FADDR_W 17
`define HALT_START 17'h1F000

// reset values
`define LOCKS_RST 4'hF
`define BOOT_START_RST 17'h1F000
`define OP_TIME_RST 16'h0190
`define VECTOR_RST 1'b0

// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ### rtl/flash_guard_pkg.sv
package flash_guard_pkg;

    typedef enum logic [2:0] {
        OP_BUFFER,
        OP_ERASE,
        OP_WRITE,
        OP_LOCK,
        OP_READ_EN
    } store_op_e;

    typedef enum logic {
        ST_IDLE,
        ST_PROG
    } prog_state_e;

endpackage

// ### rtl/flash_self_program_guard.sv
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
`include "flash_guard_regs.svh"

module flash_self_program_guard
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [`FADDR_W-1:0] pc_addr,
    input wire logic store_valid,
    input wire flash_guard_pkg::store_op_e store_op,
    input wire logic [`FADDR_W-1:0] store_addr,
    input wire logic [3:0] store_data,
    output logic store_accept,
    output logic store_blocked,
    input wire logic load_valid,
    input wire logic [`FADDR_W-1:0] load_addr,
    output logic load_ok,
    output logic load_blocked,
    output logic cpu_halt,
    output logic concurrent_section_busy,
    output logic irq_suppress,
    output logic prog_start,
    output logic prog_erase,
    output logic [`FADDR_W-1:0] prog_page_addr,
    output logic prog_done,
    input wire logic ext_lock_we,
    input wire logic [3:0] ext_lock_data,
    input wire logic chip_erase
);
    import flash_guard_pkg::*;

    // axi group
    logic aw_have_reg, aw_have_next;
    logic w_have_reg, w_have_next;
    logic [7:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;

    // core group
    prog_state_e state_reg, state_next;
    logic [15:0] count_reg, count_next;
    logic halt_reg, halt_next;
    logic cbusy_reg, cbusy_next;
    logic [3:0] locks_reg, locks_next;
    logic [`FADDR_W-1:0] boot_start_reg, boot_start_next;
    logic [15:0] op_time_reg, op_time_next;
    logic vec_boot_reg, vec_boot_next;
    logic [`FADDR_W-1:0] page_reg, page_next;
    logic erase_reg, erase_next;
    logic start_reg, start_next;
    logic done_reg, done_next;
    logic accept_reg, accept_next;
    logic sblock_reg, sblock_next;
    logic lok_reg, lok_next;
    logic lblock_reg, lblock_next;
    logic srefused_reg, srefused_next;
    logic lrefused_reg, lrefused_next;
    logic irq_sup_reg, irq_sup_next;

    logic [`FADDR_W-1:0] eff_boot_start;
    logic wr_fire;
    logic wr_hit;
    logic [7:0] wr_addr;
    logic [31:0] wr_mask;
    logic [31:0] wr_data;

    // boot section start never lies below the halting section
    assign eff_boot_start = (boot_start_reg < `HALT_START) ? `HALT_START : boot_start_reg;

    function automatic logic in_halting(input logic [`FADDR_W-1:0] a);
        in_halting = (a >= `HALT_START);
    endfunction

    function automatic logic [31:0] reg_read(input logic [7:0] a);
        reg_read = 32'h0000_0000;
        unique case ({a[7:2], 2'b00})
            `REG_STATUS:
            begin
                reg_read[`ST_PROG_BUSY] = (state_reg == ST_PROG);
                reg_read[`ST_CONC_BUSY] = cbusy_reg;
                reg_read[`ST_CPU_HALT] = halt_reg;
                reg_read[`ST_STORE_REFUSED] = srefused_reg;
                reg_read[`ST_LOAD_REFUSED] = lrefused_reg;
            end
            `REG_LOCKS: reg_read[3:0] = locks_reg;
            `REG_BOOT_START: reg_read[`FADDR_W-1:0] = boot_start_reg;
            `REG_OP_TIME: reg_read[15:0] = op_time_reg;
            `REG_VECTOR: reg_read[`VEC_IN_BOOT] = vec_boot_reg;
            default: reg_read = 32'h0000_0000;
        endcase
    endfunction

    function automatic logic reg_mapped(input logic [7:0] a);
        unique case ({a[7:2], 2'b00})
            `REG_STATUS, `REG_LOCKS, `REG_BOOT_START, `REG_OP_TIME, `REG_VECTOR:
                reg_mapped = 1'b1;
            default: reg_mapped = 1'b0;
        endcase
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_strb
            assign wr_mask[8*gi +: 8] = {8{wstrb_reg[gi]}};
        end
    endgenerate

    assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
    assign wr_addr = {awaddr_reg[7:2], 2'b00};
    assign wr_hit = reg_mapped(awaddr_reg);
    // comb process so the merge follows register changes, not only the address
    always_comb
    begin
        wr_data = (reg_read(awaddr_reg) & ~wr_mask) | (wdata_reg & wr_mask);
    end

    always_comb
    begin
        aw_have_next = aw_have_reg;
        w_have_next = w_have_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_awvalid && awready_reg)
        begin
            aw_have_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg)
        begin
            w_have_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        if (wr_fire)
        begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (bvalid_reg && s_axi_bready)
        begin
            bvalid_next = 1'b0;
        end
        if (rvalid_reg && s_axi_rready)
        begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && arready_reg)
        begin
            rvalid_next = 1'b1;
            rdata_next = reg_read(s_axi_araddr);
            rresp_next = reg_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end
        awready_next = !aw_have_next && !bvalid_next;
        wready_next = !w_have_next && !bvalid_next;
        arready_next = !rvalid_next;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `RESP_OKAY;
        end
        else
        begin
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    logic pc_boot;
    logic st_boot;
    logic st_wr_locked;
    logic ld_boot;
    logic ld_locked;
    logic [3:0] lock_clear;

    assign pc_boot = (pc_addr >= eff_boot_start);
    assign st_boot = (store_addr >= eff_boot_start);
    // only the write lock bit of each section pair gates erase and write stores; general lock modes play no part
    assign st_wr_locked = st_boot ? !locks_reg[`LOCK_BOOT_WR]
                                  : !locks_reg[`LOCK_APP_WR];
    assign ld_boot = (load_addr >= eff_boot_start);
    assign ld_locked = (pc_boot && !ld_boot && !locks_reg[`LOCK_APP_RD])
                    || (!pc_boot && ld_boot && !locks_reg[`LOCK_BOOT_RD]);

    always_comb
    begin
        state_next = state_reg;
        count_next = count_reg;
        halt_next = halt_reg;
        cbusy_next = cbusy_reg;
        boot_start_next = boot_start_reg;
        op_time_next = op_time_reg;
        vec_boot_next = vec_boot_reg;
        page_next = page_reg;
        erase_next = erase_reg;
        start_next = 1'b0;
        done_next = 1'b0;
        accept_next = 1'b0;
        sblock_next = 1'b0;
        lok_next = 1'b0;
        lblock_next = 1'b0;
        srefused_next = srefused_reg;
        lrefused_next = lrefused_reg;
        lock_clear = 4'hF;
        if (wr_fire && wr_addr == `REG_LOCKS)
        begin
            lock_clear = lock_clear & wr_data[3:0];
        end
        if (wr_fire && wr_addr == `REG_BOOT_START)
        begin
            boot_start_next = wr_data[`FADDR_W-1:0];
        end
        if (wr_fire && wr_addr == `REG_OP_TIME)
        begin
            op_time_next = wr_data[15:0];
        end
        if (wr_fire && wr_addr == `REG_VECTOR)
        begin
            vec_boot_next = wr_data[`VEC_IN_BOOT];
        end
        if (ext_lock_we)
        begin
            lock_clear = lock_clear & ext_lock_data;
        end
        unique case (state_reg)
            ST_IDLE:
            begin
                if (store_valid)
                begin
                    if (!pc_boot)
                    begin
                        sblock_next = 1'b1;
                    end
                    else
                    begin
                        unique case (store_op)
                            OP_ERASE, OP_WRITE:
                            begin
                                if (st_wr_locked)
                                begin
                                    sblock_next = 1'b1;
                                end
                                else
                                begin
                                    accept_next = 1'b1;
                                    start_next = 1'b1;
                                    state_next = ST_PROG;
                                    page_next = store_addr;
                                    erase_next = (store_op == OP_ERASE);
                                    count_next = (op_time_reg == 16'h0000) ? 16'h0001
                                                                          : op_time_reg;
                                    if (in_halting(store_addr))
                                    begin
                                        halt_next = 1'b1;
                                    end
                                    else
                                    begin
                                        cbusy_next = 1'b1;
                                    end
                                end
                            end
                            OP_LOCK:
                            begin
                                accept_next = 1'b1;
                                lock_clear = lock_clear & store_data;
                            end
                            OP_READ_EN, OP_BUFFER:
                            begin
                                accept_next = 1'b1;
                                cbusy_next = 1'b0;
                            end
                            default: sblock_next = 1'b1;
                        endcase
                    end
                end
            end
            ST_PROG:
            begin
                // one page operation at a time; busy cannot be released mid-operation
                if (store_valid)
                begin
                    sblock_next = 1'b1;
                end
                count_next = count_reg - 16'h0001;
                if (count_reg <= 16'h0001)
                begin
                    state_next = ST_IDLE;
                    halt_next = 1'b0;
                    done_next = 1'b1;
                    count_next = 16'h0000;
                end
            end
        endcase
        if (accept_next)
        begin
            srefused_next = 1'b0;
        end
        if (sblock_next)
        begin
            srefused_next = 1'b1;
        end
        if (load_valid)
        begin
            // while busy the concurrent section returns nothing; halted means no reads
            if (halt_reg || (cbusy_reg && !in_halting(load_addr)) || ld_locked)
            begin
                lblock_next = 1'b1;
                lrefused_next = 1'b1;
            end
            else
            begin
                lok_next = 1'b1;
                lrefused_next = 1'b0;
            end
        end
        locks_next = chip_erase ? `LOCKS_RST : (locks_reg & lock_clear);
        irq_sup_next = (!locks_reg[`LOCK_APP_RD] && vec_boot_reg && !pc_boot)
                    || (!locks_reg[`LOCK_BOOT_RD] && !vec_boot_reg && pc_boot);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= ST_IDLE;
            count_reg <= 16'h0000;
            halt_reg <= 1'b0;
            cbusy_reg <= 1'b0;
            locks_reg <= `LOCKS_RST;
            boot_start_reg <= `BOOT_START_RST;
            op_time_reg <= `OP_TIME_RST;
            vec_boot_reg <= `VECTOR_RST;
            page_reg <= {`FADDR_W{1'b0}};
            erase_reg <= 1'b0;
            start_reg <= 1'b0;
            done_reg <= 1'b0;
            accept_reg <= 1'b0;
            sblock_reg <= 1'b0;
            lok_reg <= 1'b0;
            lblock_reg <= 1'b0;
            srefused_reg <= 1'b0;
            lrefused_reg <= 1'b0;
            irq_sup_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            count_reg <= count_next;
            halt_reg <= halt_next;
            cbusy_reg <= cbusy_next;
            locks_reg <= locks_next;
            boot_start_reg <= boot_start_next;
            op_time_reg <= op_time_next;
            vec_boot_reg <= vec_boot_next;
            page_reg <= page_next;
            erase_reg <= erase_next;
            start_reg <= start_next;
            done_reg <= done_next;
            accept_reg <= accept_next;
            sblock_reg <= sblock_next;
            lok_reg <= lok_next;
            lblock_reg <= lblock_next;
            srefused_reg <= srefused_next;
            lrefused_reg <= lrefused_next;
            irq_sup_reg <= irq_sup_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign store_accept = accept_reg;
    assign store_blocked = sblock_reg;
    assign load_ok = lok_reg;
    assign load_blocked = lblock_reg;
    assign cpu_halt = halt_reg;
    assign concurrent_section_busy = cbusy_reg;
    assign irq_suppress = irq_sup_reg;
    assign prog_start = start_reg;
    assign prog_erase = erase_reg;
    assign prog_page_addr = page_reg;
    assign prog_done = done_reg;

endmodule

// ### tb/flash_guard_properties.sv
`timescale 1ns/10ps
`include "flash_guard_regs.svh"
module flash_guard_properties
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [`FADDR_W-1:0] pc_addr,
    input wire logic store_valid,
    input wire flash_guard_pkg::store_op_e store_op,
    input wire logic store_accept,
    input wire logic store_blocked,
    input wire logic load_valid,
    input wire logic [`FADDR_W-1:0] load_addr,
    input wire logic load_ok,
    input wire logic load_blocked,
    input wire logic cpu_halt,
    input wire logic concurrent_section_busy,
    input wire logic prog_start,
    input wire logic prog_erase,
    input wire logic [`FADDR_W-1:0] prog_page_addr,
    input wire logic prog_done
);
    import flash_guard_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_halt_start: assert property (prog_start && prog_page_addr >= `HALT_START
        |-> cpu_halt) else $error("halting page op left cpu running");
    chk_concurrent_run: assert property (prog_start && prog_page_addr < `HALT_START
        |-> !cpu_halt && concurrent_section_busy) else $error("concurrent page op misflagged");
    chk_halt_until_done: assert property ($fell(cpu_halt) |-> prog_done)
        else $error("halt ended before page op done");
    chk_halt_load: assert property (load_valid && cpu_halt |=> load_blocked && !load_ok)
        else $error("load served during halt");
    chk_busy_load: assert property (
        load_valid && concurrent_section_busy && load_addr < `HALT_START |=> load_blocked)
        else $error("busy concurrent section was read");
    chk_store_from_app: assert property (
        store_valid && pc_addr < `HALT_START |=> store_blocked && !store_accept)
        else $error("store from application section taken");
    chk_start_needs_accept: assert property (prog_start
        |-> store_accept && $past(store_op) inside {OP_ERASE, OP_WRITE})
        else $error("page op started without accepted store");
    chk_busy_clear: assert property ($fell(concurrent_section_busy)
        |-> store_accept && $past(store_op) inside {OP_READ_EN, OP_BUFFER})
        else $error("busy cleared without read enable");
    chk_load_answer: assert property (load_valid |=> load_ok != load_blocked)
        else $error("load not answered once");
    chk_store_answer: assert property (store_valid |=> store_accept != store_blocked)
        else $error("store not answered once");
    chk_erase_kind: assert property (prog_start
        |-> prog_erase == ($past(store_op) == OP_ERASE)) else $error("erase kind wrong");

    cover property (prog_start && cpu_halt);
    cover property (prog_start && concurrent_section_busy && !cpu_halt);
    cover property (load_blocked);
    cover property (store_blocked);
endmodule

// ### tb/cpu_core_model.sv
`timescale 1ns/10ps
`include "flash_guard_regs.svh"
module cpu_core_model
(
    input wire logic clk,
    output logic [`FADDR_W-1:0] pc_addr,
    output logic store_valid,
    output flash_guard_pkg::store_op_e store_op,
    output logic [`FADDR_W-1:0] store_addr,
    output logic [3:0] store_data,
    output logic load_valid,
    output logic [`FADDR_W-1:0] load_addr,
    input wire logic store_accept,
    input wire logic store_blocked,
    input wire logic load_ok,
    input wire logic load_blocked,
    input wire logic concurrent_section_busy,
    input wire logic prog_start,
    input wire logic prog_done
);
    import flash_guard_pkg::*;
    logic prog_run = 1'b0;

    initial
    begin
        pc_addr = 17'h1F800;
        store_valid = 1'b0;
        store_op = OP_BUFFER;
        store_addr = 17'h0;
        store_data = 4'hF;
        load_valid = 1'b0;
        load_addr = 17'h0;
    end

    always @(posedge clk)
    begin
        if (prog_start)
            prog_run <= 1'b1;
        else if (prog_done)
            prog_run <= 1'b0;
    end

    task automatic set_pc(input logic [`FADDR_W-1:0] a);
        @(posedge clk);
        pc_addr <= a;
        repeat (3) @(posedge clk);
    endtask

    // released address and data lines show the inverse of the last value
    task automatic store(input store_op_e op, input logic [`FADDR_W-1:0] a,
                         input logic [3:0] d, output logic [1:0] res);
        @(posedge clk);
        store_valid <= 1'b1;
        store_op <= op;
        store_addr <= a;
        store_data <= d;
        @(posedge clk);
        store_valid <= 1'b0;
        store_addr <= ~a;
        store_data <= ~d;
        #1 res = {store_accept, store_blocked};
    endtask

    task automatic load(input logic [`FADDR_W-1:0] a, input bit rude, output logic [1:0] res);
        logic [1:0] r;
        int n;
        if (!rude && concurrent_section_busy && a < `HALT_START)
        begin
            n = 0;
            while (prog_run && n < 5000)
            begin
                @(posedge clk);
                n++;
            end
            store(OP_READ_EN, a, 4'hF, r);
        end
        @(posedge clk);
        load_valid <= 1'b1;
        load_addr <= a;
        @(posedge clk);
        load_valid <= 1'b0;
        load_addr <= ~a;
        #1 res = {load_ok, load_blocked};
    endtask
endmodule

// ### tb/flash_self_program_guard_tb.sv
`timescale 1ns/10ps
`include "flash_guard_regs.svh"
module flash_self_program_guard_tb;
    import flash_guard_pkg::*;
    localparam int OP_T = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [`FADDR_W-1:0] pc_addr, store_addr, load_addr, prog_page_addr;
    store_op_e store_op;
    logic [3:0] store_data;
    logic [3:0] ext_lock_data = 4'hF;
    logic ext_lock_we = 1'b0, chip_erase = 1'b0;
    logic store_valid, store_accept, store_blocked, load_valid, load_ok, load_blocked;
    logic cpu_halt, concurrent_section_busy, irq_suppress, prog_start, prog_erase, prog_done;
    logic [1:0] modes [4] = '{2'b11, 2'b10, 2'b00, 2'b01};
    logic [31:0] rd;
    logic [1:0] rs, m;
    int fails = 0;
    int checked = 0;

    always #5 clk = ~clk;

    flash_self_program_guard DUT (.*);
    cpu_core_model cpu (.*);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (fails == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done)
        begin
            @(posedge clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                done = 1'b1;
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 1'b0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done)
        begin
            @(posedge clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                done = 1'b1;
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end
    endtask

    task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        axi_rd(a, rd, rs);
        check(rd, exp);
        check(rs, er);
    endtask

    task automatic clear_locks();
        @(posedge clk);
        chip_erase <= 1'b1;
        @(posedge clk);
        chip_erase <= 1'b0;
    endtask

    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        reg_chk(`REG_STATUS, 32'h0, `RESP_OKAY);
        reg_chk(`REG_LOCKS, 32'hF, `RESP_OKAY);
        reg_chk(`REG_BOOT_START, 32'h1F000, `RESP_OKAY);
        reg_chk(`REG_OP_TIME, 32'h190, `RESP_OKAY);
        reg_chk(`REG_VECTOR, 32'h0, `RESP_OKAY);
        reg_chk(8'h14, 32'h0, `RESP_SLVERR);
        axi_wr(8'h14, 32'h0, rs);
        check(rs, `RESP_SLVERR);
        axi_wr(`REG_OP_TIME, OP_T, rs);
        axi_wr(`REG_BOOT_START, 32'h100, rs);
        reg_chk(`REG_BOOT_START, 32'h100, `RESP_OKAY);
        @(posedge clk);
        ext_lock_data <= 4'hE;
        ext_lock_we <= 1'b1;
        @(posedge clk);
        ext_lock_we <= 1'b0;
        ext_lock_data <= 4'h1;
        reg_chk(`REG_LOCKS, 32'hE, `RESP_OKAY);
        axi_wr(`REG_LOCKS, 32'h7, rs);
        reg_chk(`REG_LOCKS, 32'h6, `RESP_OKAY);
        clear_locks();
        reg_chk(`REG_LOCKS, 32'hF, `RESP_OKAY);
        // page op in the concurrent section
        cpu.store(OP_ERASE, 17'h00100, 4'hF, rs);
        check(rs, 2'b10);
        check(cpu_halt, 1'b0);
        check(concurrent_section_busy, 1'b1);
        cpu.load(17'h1F100, 1'b1, rs);
        check(rs, 2'b10);
        cpu.load(17'h00200, 1'b1, rs);
        check(rs, 2'b01);
        repeat (OP_T + 4) @(posedge clk);
        check(concurrent_section_busy, 1'b1);
        cpu.load(17'h00200, 1'b0, rs);
        check(rs, 2'b10);
        check(concurrent_section_busy, 1'b0);
        // page op in the halting section
        cpu.store(OP_WRITE, 17'h1F080, 4'hF, rs);
        check(rs, 2'b10);
        check(cpu_halt, 1'b1);
        cpu.load(17'h1F100, 1'b1, rs);
        check(rs, 2'b01);
        cpu.store(OP_ERASE, 17'h00100, 4'hF, rs);
        check(rs, 2'b01);
        check(cpu_halt, 1'b1);
        repeat (OP_T) @(posedge clk);
        check(cpu_halt, 1'b0);
        cpu.set_pc(17'h00200);
        cpu.store(OP_ERASE, 17'h00100, 4'hF, rs);
        check(rs, 2'b01);
        axi_rd(`REG_STATUS, rd, rs);
        check(rd[3], 1'b1);
        cpu.set_pc(17'h1F800);
        // same mode on both lock pairs
        foreach (modes[i])
        begin
            m = modes[i];
            clear_locks();
            cpu.store(OP_LOCK, 17'h0, {m, m}, rs);
            reg_chk(`REG_LOCKS, {28'h0, m, m}, `RESP_OKAY);
            cpu.load(17'h00200, 1'b0, rs);
            check(rs, {m[1], !m[1]});
            check(irq_suppress, !m[1]);
            cpu.set_pc(17'h00010);
            check(irq_suppress, 1'b0);
            cpu.load(17'h1F900, 1'b0, rs);
            check(rs, {m[1], !m[1]});
            axi_wr(`REG_VECTOR, 32'h1, rs);
            cpu.set_pc(17'h00010);
            check(irq_suppress, !m[1]);
            axi_wr(`REG_VECTOR, 32'h0, rs);
            cpu.set_pc(17'h1F800);
            cpu.store(OP_WRITE, 17'h1F900, 4'hF, rs);
            check(rs, {m[0], !m[0]});
            repeat (OP_T + 4) @(posedge clk);
            cpu.store(OP_ERASE, 17'h00400, 4'hF, rs);
            check(rs, {m[0], !m[0]});
            repeat (OP_T + 4) @(posedge clk);
            cpu.store(OP_BUFFER, 17'h0, 4'hF, rs);
            check(concurrent_section_busy, 1'b0);
        end
        print_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        $display("unexpected at %0t: timeout", $time);
        print_verdict();
    end
endmodule

bind flash_self_program_guard flash_guard_properties chk (.*);
